/* rtl/flash_host_cfg.svh */
// constants for the flash erase/status host controller
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
`define CLK_PERIOD_NS 10
`define CMD_CHIP_ERASE 8'h10
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_ERASE_SETUP 8'h80
`define ADDR_UNLOCK1 20'h00555
`define ADDR_UNLOCK2 20'h002AA
`define PULSE_NS 40
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC 2
`define READ_NS 70
`define READ_CYC ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_LATENCY_US 10
`define SUSPEND_LATENCY_CYC (`SUSPEND_LATENCY_US * 1000 / `CLK_PERIOD_NS)
`define RESET_PULSE_MIN_NS 500
`define RESET_PULSE_CYC ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOVERY_MIN_NS 50
`define RESET_RECOVERY_CYC ((`RESET_RECOVERY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_POLL_POS 7
`define PRIMARY_TOGGLE_POS 6
`define AUX_TOGGLE_POS 2
`endif

/* rtl/flash_host_pkg.sv */
// types for the flash erase/status host controller
package flash_host_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SETUP = 4'b0001,
    ST_PULSE = 4'b0010,
    ST_HOLD = 4'b0011,
    ST_POLL_SETUP = 4'b0100,
    ST_POLL_WAIT = 4'b0101,
    ST_POLL_EVAL = 4'b0110,
    ST_SUSP_WAIT = 4'b0111,
    ST_RESET = 4'b1000,
    ST_RECOVER = 4'b1001
  } state_t;
  typedef enum logic [1:0] {
    OP_CHIP_ERASE = 2'b00,
    OP_SUSPEND = 2'b01,
    OP_RESUME = 2'b10,
    OP_RESET = 2'b11
  } op_t;
endpackage

/* rtl/flash_erase_host.sv */
// host controller issuing chip erase, suspend, resume and reset to the flash
// Operation
// - chip erase: six writes, 10H at 555H
// - B0H suspends; read mode within 10 us
// - 30H at any address resumes erase
// - status reads address the busy bank
// - hold protect high through whole write
// - reissue erase interrupted by reset; the controller does not reissue it, a reset ends with done and erase_ok low
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_erase_host #(
  parameter int SUSPEND_CYC = `SUSPEND_LATENCY_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [19:0] cmd_addr,
  input wire logic cmd_unprotect,
  output logic cmd_ready,
  output logic done,
  output logic erase_ok,
  output logic busy,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [15:0] flash_dq_in,
  output logic flash_bank_enable_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic reset_n,
  output logic write_protect_n,
  output logic width_select,
  input wire logic ready_busy_n
);
  flash_host_pkg::state_t state;
  flash_host_pkg::op_t op;
  logic [2:0] step;
  logic [2:0] last_step;
  logic [15:0] cnt;
  logic [19:0] poll_addr;
  logic prev_toggle;
  logic have_prev;

  // unlock sequence or suspend/resume command addresses and data for each bus write
  function automatic logic [27:0] seq_word(input flash_host_pkg::op_t o, input logic [2:0] s,
                                           input logic [19:0] a);
    logic [27:0] w;
    w = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
    if (o == flash_host_pkg::OP_SUSPEND) begin
      w = {a, `CMD_SUSPEND};
    end else if (o == flash_host_pkg::OP_RESUME) begin
      w = {a, `CMD_RESUME};
    end else begin
      unique case (s)
        3'h0: w = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
        3'h1: w = {`ADDR_UNLOCK2, `CMD_UNLOCK2};
        3'h2: w = {`ADDR_UNLOCK1, `CMD_ERASE_SETUP};
        3'h3: w = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
        3'h4: w = {`ADDR_UNLOCK2, `CMD_UNLOCK2};
        default: w = {`ADDR_UNLOCK1, `CMD_CHIP_ERASE};
      endcase
    end
    return w;
  endfunction

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= flash_host_pkg::ST_IDLE;
      op <= flash_host_pkg::OP_CHIP_ERASE;
      step <= 3'h0;
      last_step <= 3'h0;
      cnt <= 16'h0000;
      poll_addr <= 20'h00000;
      prev_toggle <= 1'b0;
      have_prev <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      erase_ok <= 1'b0;
      busy <= 1'b0;
      flash_addr <= 20'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_bank_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      reset_n <= 1'b1;
      write_protect_n <= 1'b0;
      width_select <= 1'b1;
    end else begin
      done <= 1'b0;
      width_select <= 1'b1;
      unique case (state)
        flash_host_pkg::ST_IDLE: begin
          cmd_ready <= 1'b1;
          busy <= 1'b0;
          flash_dq_oe_n <= 1'b1;
          output_enable_n <= 1'b1;
          flash_bank_enable_n <= 1'b1;
          write_enable_n <= 1'b1;
          // a request before ready rises after reset or done is refused, not queued
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            busy <= 1'b1;
            op <= flash_host_pkg::op_t'(cmd_op);
            poll_addr <= cmd_addr;
            step <= 3'h0;
            cnt <= 16'h0000;
            // protect set from cmd_unprotect before the first write; dropped at done after erase or reset only
            write_protect_n <= cmd_unprotect;
            if (cmd_op == flash_host_pkg::OP_RESET) begin
              reset_n <= 1'b0;
              state <= flash_host_pkg::ST_RESET;
            end else begin
              last_step <= (cmd_op == flash_host_pkg::OP_CHIP_ERASE) ? 3'h5 : 3'h0;
              state <= flash_host_pkg::ST_SETUP;
            end
          end
        end
        flash_host_pkg::ST_SETUP: begin
          // output enable kept high so the write is not inhibited
          output_enable_n <= 1'b1;
          flash_dq_oe_n <= 1'b0;
          {flash_addr, flash_dq_out[7:0]} <= seq_word(op, step, poll_addr);
          flash_dq_out[15:8] <= 8'h00;
          flash_bank_enable_n <= 1'b0;
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(`SETUP_CYC - 1)) begin
            write_enable_n <= 1'b0;
            cnt <= 16'h0000;
            state <= flash_host_pkg::ST_PULSE;
          end
        end
        flash_host_pkg::ST_PULSE: begin
          // strobe well above the glitch filter width
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(`PULSE_CYC - 1)) begin
            write_enable_n <= 1'b1;
            cnt <= 16'h0000;
            state <= flash_host_pkg::ST_HOLD;
          end
        end
        flash_host_pkg::ST_HOLD: begin
          flash_bank_enable_n <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          if (step != last_step) begin
            step <= step + 3'h1;
            state <= flash_host_pkg::ST_SETUP;
          end else if (op == flash_host_pkg::OP_SUSPEND) begin
            state <= flash_host_pkg::ST_SUSP_WAIT;
          end else if (op == flash_host_pkg::OP_RESUME) begin
            done <= 1'b1;
            erase_ok <= 1'b1;
            state <= flash_host_pkg::ST_IDLE;
          end else begin
            have_prev <= 1'b0;
            state <= flash_host_pkg::ST_POLL_SETUP;
          end
        end
        flash_host_pkg::ST_POLL_SETUP: begin
          // only status reads during the erase, in the erasing bank
          flash_addr <= poll_addr;
          flash_bank_enable_n <= 1'b0;
          output_enable_n <= 1'b0;
          cnt <= 16'h0000;
          state <= flash_host_pkg::ST_POLL_WAIT;
        end
        flash_host_pkg::ST_POLL_WAIT: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(`READ_CYC - 1)) begin
            state <= flash_host_pkg::ST_POLL_EVAL;
          end
        end
        flash_host_pkg::ST_POLL_EVAL: begin
          output_enable_n <= 1'b1;
          flash_bank_enable_n <= 1'b1;
          prev_toggle <= flash_dq_in[`PRIMARY_TOGGLE_POS];
          have_prev <= 1'b1;
          // finished when toggling stops, polling reads 1 and the pin is released
          if (have_prev && prev_toggle == flash_dq_in[`PRIMARY_TOGGLE_POS]
              && flash_dq_in[`DATA_POLL_POS] && ready_busy_n) begin
            done <= 1'b1;
            erase_ok <= 1'b1;
            write_protect_n <= 1'b0;
            state <= flash_host_pkg::ST_IDLE;
          end else begin
            state <= flash_host_pkg::ST_POLL_SETUP;
          end
        end
        flash_host_pkg::ST_SUSP_WAIT: begin
          // wait out the suspend latency before reading elsewhere
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(SUSPEND_CYC - 1)) begin
            done <= 1'b1;
            erase_ok <= 1'b1;
            state <= flash_host_pkg::ST_IDLE;
          end
        end
        flash_host_pkg::ST_RESET: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(`RESET_PULSE_CYC - 1)) begin
            reset_n <= 1'b1;
            cnt <= 16'h0000;
            state <= flash_host_pkg::ST_RECOVER;
          end
        end
        flash_host_pkg::ST_RECOVER: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(`RESET_RECOVERY_CYC - 1)) begin
            // an erase cut short is not complete; user must reissue it
            erase_ok <= 1'b0;
            done <= 1'b1;
            write_protect_n <= 1'b0;
            state <= flash_host_pkg::ST_IDLE;
          end
        end
        default: state <= flash_host_pkg::ST_IDLE;
      endcase
    end
  end
endmodule

/* tb/flash_device_model.sv */
// behavioural flash device: chip erase sequence, status reads, ready pin
`timescale 1ns/1ps
module flash_device_model #(
  parameter int POLLS = 3
) (
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_bank_enable_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic reset_n,
  input wire logic write_protect_n,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_n
);
  localparam logic [19:0] SEQ_A [6] = '{20'h00555, 20'h002AA, 20'h00555,
    20'h00555, 20'h002AA, 20'h00555};
  localparam logic [7:0] SEQ_D [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h10};
  int step = 0;
  int reads = 0;
  int busy_until = 0;
  logic tog = 1'h0;
  logic erasing;
  realtime t_fall = 0.0;
  // write side moves the end mark, read side counts reads: one writer per variable
  assign erasing = (reads < busy_until);
  always @(negedge write_enable_n) t_fall = $realtime;
  always @(posedge write_enable_n or negedge reset_n) begin
    if (!reset_n) begin
      step = 0;
      busy_until = reads;
    end else if (!flash_bank_enable_n && output_enable_n && $realtime - t_fall >= 5.0
                 && !erasing) begin
      if (flash_addr == SEQ_A[step] && flash_dq_out[7:0] == SEQ_D[step]) begin
        if (step == 5 && write_protect_n) busy_until = reads + POLLS;
        step = (step == 5) ? 0 : step + 1;
      end else step = 0;
    end
  end
  // erase length counted in status reads so slow and quick answers are one knob
  always @(negedge output_enable_n) begin
    if (!flash_bank_enable_n && erasing) begin
      reads = reads + 1;
      tog = ~tog;
    end
  end
  assign ready_busy_n = erasing ? 1'h0 : 1'h1;
  always_comb begin
    if (!flash_bank_enable_n && !output_enable_n)
      flash_dq_in = erasing ? {9'h000, tog, 3'h0, tog, 2'h0} : 16'hFFFF;
    else flash_dq_in = 16'h5A5A ^ {16{tog}};
  end
endmodule

/* tb/flash_erase_host_properties.sv */
// port assertions for the flash erase host controller
`timescale 1ns/1ps
module flash_erase_host_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_bank_enable_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic reset_n,
  input wire logic write_protect_n,
  input wire logic width_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_write_inhibit: assert property (!write_enable_n |-> output_enable_n && !flash_bank_enable_n)
    else $error("write strobe outside a selected write");
  a_no_contention: assert property (!output_enable_n |-> flash_dq_oe_n)
    else $error("host drives data during a read");
  a_wide_bus: assert property (width_select)
    else $error("bus not in sixteen bit mode");
  a_pulse_width: assert property ($fell(write_enable_n) |-> !write_enable_n[*4] ##1 write_enable_n)
    else $error("write pulse not four cycles");
  a_erase_addr: assert property ($rose(write_enable_n) && flash_dq_out[7:0] == 8'h10 |->
    flash_addr == 20'h00555) else $error("erase command at wrong address");
  a_protect_hold: assert property (!flash_bank_enable_n && $past(!flash_bank_enable_n) |->
    $stable(write_protect_n)) else $error("protect changed during access");
  a_ready_drops: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("second request accepted");
  a_reset_pulse: assert property ($fell(reset_n) |-> !reset_n[*8])
    else $error("device reset pulse too short");
endmodule
bind flash_erase_host flash_erase_host_properties i_props (.clk_sys, .reset, .cmd_valid,
  .cmd_ready, .flash_addr, .flash_dq_out, .flash_dq_oe_n, .flash_bank_enable_n,
  .write_enable_n, .output_enable_n, .reset_n, .write_protect_n, .width_select);

/* tb/flash_erase_host_test.sv */
// self-checking bench for the flash erase host controller
`timescale 1ns/1ps
module flash_erase_host_test;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic cmd_valid = 1'h0;
  logic [1:0] cmd_op = 2'h0;
  logic [19:0] cmd_addr = 20'h00000;
  logic cmd_unprotect = 1'h0;
  logic seen_busy = 1'h0;
  logic cmd_ready, done, erase_ok, busy, flash_dq_oe_n, flash_bank_enable_n, write_enable_n;
  logic output_enable_n, reset_n, write_protect_n, width_select, ready_busy_n, r_u;
  logic [1:0] r_op;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic [2:0] exp_q [$];
  int bad_count = 0;
  int n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  flash_erase_host #(.SUSPEND_CYC(4)) i_dut (.clk_sys, .reset, .cmd_valid, .cmd_op, .cmd_addr,
    .cmd_unprotect, .cmd_ready, .done, .erase_ok, .busy, .flash_addr, .flash_dq_out,
    .flash_dq_oe_n, .flash_dq_in, .flash_bank_enable_n, .write_enable_n, .output_enable_n,
    .reset_n, .write_protect_n, .width_select, .ready_busy_n);
  flash_device_model #(.POLLS(3)) i_dev (.flash_addr, .flash_dq_out, .flash_bank_enable_n,
    .write_enable_n, .output_enable_n, .reset_n, .write_protect_n, .flash_dq_in, .ready_busy_n);
  always @(negedge ready_busy_n) seen_busy = 1'h1;
  task automatic check(string name, logic [2:0] seen, logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expectation: {erase_ok, device went busy, ready pin at completion}
  task automatic run_op(logic [1:0] op, logic unprot, logic [2:0] exp);
    int i;
    for (i = 0; i < 100 && cmd_ready !== 1'h1; i++) @(negedge clk_sys);
    seen_busy = 1'h0;
    exp_q.push_back(exp);
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_addr = 20'($urandom);
    cmd_unprotect = unprot;
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    check("busy ready", {1'h0, busy, cmd_ready}, 3'h2);
    for (i = 0; i < 3000 && done !== 1'h1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    check("idle ready", {1'h0, busy, cmd_ready}, 3'h1);
  endtask
  // results are looked at mid-cycle, after the done edge has settled
  always @(negedge clk_sys) begin
    if (done === 1'h1) begin
      if (exp_q.size() == 0) check("extra done", 3'h1, 3'h0);
      else check("result", {erase_ok, seen_busy, ready_busy_n}, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(39732));
    repeat (4) @(negedge clk_sys);
    check("reset outputs", {cmd_ready, write_protect_n, reset_n}, 3'h1);
    reset = 1'h0;
    run_op(2'h0, 1'h1, 3'h7);
    run_op(2'h0, 1'h0, 3'h5);
    run_op(2'h1, 1'h1, 3'h5);
    run_op(2'h2, 1'h1, 3'h5);
    run_op(2'h3, 1'h1, 3'h1);
    run_op(2'h0, 1'h1, 3'h7);
    repeat (10) begin
      r_op = 2'($urandom);
      r_u = 1'($urandom);
      run_op(r_op, r_u, (r_op == 2'h3) ? 3'h1 : (r_op == 2'h0 && r_u) ? 3'h7 : 3'h5);
    end
    check("pending", 3'(exp_q.size()), 3'h0);
    summarize();
  end
  initial begin
    #300000;
    bad_count++;
    summarize();
  end
endmodule
